// [bench/lhrs_link_model.sv]
/*
  Link-side partner of the register slice: drives bus resets, fetch
  errors, failed posted writes and configuration ROM quadlet reads.
  Assumes the caller owns ref_clk; every pulse lasts one cycle.
*/
`timescale 1ns/1ps

module lhrs_link_model (
  // Clock
  input  wire logic        ref_clk,
  // Link events
  output logic             bus_reset,
  output logic             fetch_error,
  output logic             write_fail,
  output logic      [47:0] write_fail_offset,
  output logic      [15:0] write_fail_source,
  output logic             rom_rd_req,
  output logic      [47:0] rom_rd_offset
);
  initial begin
    bus_reset         = 1'b0;
    fetch_error       = 1'b0;
    write_fail        = 1'b0;
    write_fail_offset = 48'h0;
    write_fail_source = 16'h0;
    rom_rd_req        = 1'b0;
    rom_rd_offset     = 48'h0;
  end

  // ==========================================================
  // Event pulses
  task automatic pulse_reset(input logic err);
    @(posedge ref_clk);
    bus_reset   <= ~err;
    fetch_error <= err;
    @(posedge ref_clk);
    bus_reset   <= 1'b0;
    fetch_error <= 1'b0;
  endtask : pulse_reset

  // Fields are scrambled once released, so stale values never pass
  task automatic fail(input logic [47:0] ofs, input logic [15:0] src);
    @(posedge ref_clk);
    write_fail        <= 1'b1;
    write_fail_offset <= ofs;
    write_fail_source <= src;
    @(posedge ref_clk);
    write_fail        <= 1'b0;
    write_fail_offset <= ~ofs;
    write_fail_source <= ~src;
  endtask : fail

  task automatic rom_read(input logic [47:0] ofs);
    @(posedge ref_clk);
    rom_rd_req    <= 1'b1;
    rom_rd_offset <= ofs;
    @(posedge ref_clk);
    rom_rd_req    <= 1'b0;
    rom_rd_offset <= ~ofs;
  endtask : rom_read
endmodule : lhrs_link_model

// [bench/tb_top.sv]
/*
  Self-checking bench of the register slice: Avalon-MM register tasks
  and link events from the partner model, with expected values.
  Assumes the slice answers every request within a few cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("wrong value %s exp %h got %h", nm, exp, got); \
  end end

module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        bus_reset, fetch_error, write_fail, rom_rd_req;
  logic [47:0] write_fail_offset, rom_rd_offset;
  logic [15:0] write_fail_source;
  logic        rom_addr_valid, irq;
  logic [31:0] rom_addr, controller_flags, rd;
  int          error_cnt = 0;
  int          n_checks = 0;

  always #10 ref_clk = ~ref_clk;

  lhrs_regs i_dut (.ref_clk(ref_clk), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .bus_reset(bus_reset),
    .fetch_error(fetch_error), .write_fail(write_fail),
    .write_fail_offset(write_fail_offset),
    .write_fail_source(write_fail_source), .rom_rd_req(rom_rd_req),
    .rom_rd_offset(rom_rd_offset), .rom_addr_valid(rom_addr_valid),
    .rom_addr(rom_addr), .controller_flags(controller_flags), .irq(irq));

  lhrs_link_model i_link (.ref_clk(ref_clk), .bus_reset(bus_reset),
    .fetch_error(fetch_error), .write_fail(write_fail),
    .write_fail_offset(write_fail_offset),
    .write_fail_source(write_fail_source), .rom_rd_req(rom_rd_req),
    .rom_rd_offset(rom_rd_offset));

  // ==========================================================
  // Closing report
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Register bus; the wait is bounded so a stuck slave ends the run
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("wrong value waitrequest exp 0 got 1");
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    `CHK("readdata", e, rd)
  endtask : rdchk

  task automatic romchk(input logic [47:0] o, input logic v,
                        input logic [31:0] e);
    i_link.rom_read(o);
    #1;
    `CHK("rom_addr_valid", v, rom_addr_valid)
    if (v) `CHK("rom_addr", e, rom_addr)
  endtask : romchk

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(lhrs_pkg::ROM_BASE_OFS, 32'h0000_0000);
    rdchk(lhrs_pkg::FLAGS_SET_OFS, 32'h0080_0000);
    `CHK("controller_flags", 32'h0080_0000, controller_flags)
    $display("test reset values done");

    wr(lhrs_pkg::ROM_BASE_OFS, 32'hFFFF_FFFF);
    rdchk(lhrs_pkg::ROM_BASE_OFS, 32'hFFFF_FC00);
    bus(1'b1, lhrs_pkg::ROM_BASE_OFS, 32'h1357_9FFF, 4'h3);
    rdchk(lhrs_pkg::ROM_BASE_OFS, 32'hFFFF_9C00);
    romchk(48'hFFFF_F000_0555, 1'b1, 32'h0000_0155);
    i_link.pulse_reset(1'b0);
    romchk(48'hFFFF_F000_0555, 1'b1, 32'h0000_0155);
    wr(lhrs_pkg::FLAGS_SET_OFS, 32'h8000_0000);
    rdchk(lhrs_pkg::FLAGS_CLR_OFS, 32'h8080_0000);
    i_link.pulse_reset(1'b0);
    romchk(48'hFFFF_F000_07FF, 1'b1, 32'hFFFF_9FFF);
    romchk(48'hFFFF_F000_0400, 1'b1, 32'hFFFF_9C00);
    romchk(48'hFFFF_F000_03FC, 1'b0, 32'h0);
    romchk(48'hFFFF_F000_0800, 1'b0, 32'h0);
    i_link.pulse_reset(1'b1);
    rdchk(lhrs_pkg::FLAGS_SET_OFS, 32'h0080_0000);
    $display("test rom mapping done");

    wr(lhrs_pkg::FLAGS_SET_OFS, 32'h6047_0000);
    rdchk(lhrs_pkg::FLAGS_SET_OFS, 32'h60C7_0000);
    wr(lhrs_pkg::FLAGS_SET_OFS, 32'h8000_0000);
    rdchk(lhrs_pkg::FLAGS_SET_OFS, 32'h60C7_0000);
    wr(lhrs_pkg::FLAGS_CLR_OFS, 32'h2001_0000);
    rdchk(lhrs_pkg::FLAGS_CLR_OFS, 32'h40C6_0000);
    `CHK("controller_flags", 32'h40C6_0000, controller_flags)
    wr(lhrs_pkg::FLAGS_CLR_OFS, 32'hFFFF_FFFF);
    rdchk(lhrs_pkg::FLAGS_SET_OFS, 32'h0080_0000);
    $display("test controller flags done");

    i_link.fail(48'h1234_89AB_CDEF, {10'h2A5, 6'h1B});
    rdchk(lhrs_pkg::FAIL_LO_OFS, 32'h89AB_CDEF);
    rdchk(lhrs_pkg::FAIL_HI_OFS, {10'h2A5, 6'h1B, 16'h1234});
    wr(lhrs_pkg::FAIL_LO_OFS, 32'h0);
    wr(lhrs_pkg::FAIL_HI_OFS, 32'h0);
    rdchk(lhrs_pkg::FAIL_LO_OFS, 32'h89AB_CDEF);
    rdchk(lhrs_pkg::FAIL_HI_OFS, 32'hA95B_1234);
    wr(lhrs_pkg::ORG_ID_OFS, 32'h0);
    rdchk(lhrs_pkg::ORG_ID_OFS, lhrs_pkg::ORG_ID_VALUE);
    rdchk(8'h10, 32'h0);
    $display("test capture and id done");

    bus(1'b0, lhrs_pkg::IRQ_STAT_OFS, 32'h0, 4'hF);
    wr(lhrs_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    romchk(48'hFFFF_F000_0404, 1'b1, 32'hFFFF_9C04);
    `CHK("irq", 1'b0, irq)
    i_link.fail(48'h0, 16'h0);
    #1;
    `CHK("irq", 1'b1, irq)
    rdchk(lhrs_pkg::IRQ_STAT_OFS, 32'h0000_0005);
    #1;
    `CHK("irq", 1'b0, irq)
    rdchk(lhrs_pkg::IRQ_MASK_OFS, 32'h0000_0001);
    // Translation event lands while the status read is in flight
    fork
      rdchk(lhrs_pkg::IRQ_STAT_OFS, 32'h0000_0000);
      i_link.rom_read(48'hFFFF_F000_0408);
    join
    rdchk(lhrs_pkg::IRQ_STAT_OFS, 32'h0000_0004);
    $display("test interrupt done");

    wr(lhrs_pkg::FLAGS_SET_OFS, 32'h6047_0000);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    `CHK("controller_flags", 32'h0080_0000, controller_flags)
    `CHK("irq", 1'b0, irq)
    rdchk(lhrs_pkg::ROM_BASE_OFS, 32'h0000_0000);
    rdchk(lhrs_pkg::FLAGS_CLR_OFS, 32'h0080_0000);
    romchk(48'hFFFF_F000_0400, 1'b1, 32'h0000_0000);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : tb_top

// [src/lhrs_pkg.sv]
/*
  Constants for the link host register slice: register byte offsets,
  field positions, reset values and the configuration ROM window.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package lhrs_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ROM_BASE_OFS  = 8'h34;
  localparam logic [7:0] FAIL_LO_OFS   = 8'h38;
  localparam logic [7:0] FAIL_HI_OFS   = 8'h3C;
  localparam logic [7:0] ORG_ID_OFS    = 8'h40;
  localparam logic [7:0] FLAGS_SET_OFS = 8'h50;
  localparam logic [7:0] FLAGS_CLR_OFS = 8'h54;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h60;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h64;

  // ==========================================================
  // Field layouts
  localparam int          BASE_LSB      = 10;
  localparam logic [31:0] BASE_RW_MASK  = 32'hFFFF_FC00;
  localparam int          SRC_BUS_LSB   = 22;
  localparam int          SRC_NODE_LSB  = 16;
  localparam int          FLG_IMAGE_OK  = 31;
  localparam int          FLG_LINK_EN   = 17;
  // Flags that software may set and clear; bit 23 is read-only one
  localparam logic [31:0] FLAGS_RW_MASK = 32'hE047_0000;
  localparam logic [31:0] FLAGS_RO_ONE  = 32'h0080_0000;
  // Undefined bits 30 and 18 come out of reset as zero
  localparam logic [31:0] FLAGS_RST     = 32'h0000_0000;
  localparam logic [31:0] BASE_RST      = 32'h0000_0000;

  // ==========================================================
  // Interrupt status bits
  localparam int          IRQ_FAIL      = 0;
  localparam int          IRQ_BASE_LOAD = 1;
  localparam int          IRQ_ROM_READ  = 2;
  localparam logic [31:0] IRQ_BITS      = 32'h0000_0007;

  // ==========================================================
  // Configuration ROM window in the 48-bit 1394 offset space
  localparam logic [47:0] ROM_WIN_LO    = 48'hFFFF_F000_0400;
  localparam logic [47:0] ROM_WIN_HI    = 48'hFFFF_F000_07FF;

  // Arbitrary neutral organisation identifier
  localparam logic [31:0] ORG_ID_VALUE  = 32'h00A5_5A01;

endpackage : lhrs_pkg

// [src/lhrs_regs.sv]
/*
  Host-visible register slice of a 1394 link controller: configuration
  ROM address mapping, failed posted-write capture, organisation id,
  set/clear controller flags and an interrupt status/mask pair.
  Assumes an Avalon-MM master on ref_clk and link-side event inputs
  that are synchronous to ref_clk and one cycle wide.
*/
`timescale 1ns/1ps

module lhrs_regs (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Link-side events
  input  wire logic        bus_reset,
  input  wire logic        fetch_error,
  input  wire logic        write_fail,
  input  wire logic [47:0] write_fail_offset,
  input  wire logic [15:0] write_fail_source,
  // Configuration ROM quadlet read mapping
  input  wire logic        rom_rd_req,
  input  wire logic [47:0] rom_rd_offset,
  output logic             rom_addr_valid,
  output logic      [31:0] rom_addr,
  // Controller flags and interrupt
  output logic      [31:0] controller_flags,
  output logic             irq
);

  // ==========================================================
  // State
  typedef struct packed {
    logic        ack;
    logic [31:0] rd_data;
    logic [31:0] base_pend;
    logic [31:0] base_act;
    logic [31:0] fail_lo;
    logic [31:0] fail_hi;
    logic [31:0] flags;
    logic [31:0] status;
    logic [31:0] mask;
    logic        xl_valid;
    logic [31:0] xl_addr;
  } lhrs_state_s;

  lhrs_state_s st_r;
  lhrs_state_s st_nxt;

  // Expands byte enables into a bit mask
  function automatic logic [31:0] lhrs_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lhrs_be_mask

  logic        acc_done;
  logic        wr_done;
  logic        rd_done;
  logic [31:0] wmask;
  logic [31:0] flags_view;
  logic [31:0] rd_mux;
  logic        in_window;
  logic [31:0] ev;

  // One wait state: every request is answered on its second edge
  assign acc_done    = (read | write) & st_r.ack;
  assign wr_done     = write & st_r.ack;
  assign rd_done     = read & st_r.ack;
  assign waitrequest = (read | write) & ~st_r.ack;
  assign wmask       = writedata & lhrs_be_mask(byteenable);
  assign flags_view  = st_r.flags | lhrs_pkg::FLAGS_RO_ONE;
  assign in_window   = (rom_rd_offset >= lhrs_pkg::ROM_WIN_LO) &&
                       (rom_rd_offset <= lhrs_pkg::ROM_WIN_HI);

  // ==========================================================
  // Read multiplexer
  always_comb begin
    unique case (address)
      lhrs_pkg::ROM_BASE_OFS:  rd_mux = st_r.base_pend &
                                        lhrs_pkg::BASE_RW_MASK;
      lhrs_pkg::FAIL_LO_OFS:   rd_mux = st_r.fail_lo;
      lhrs_pkg::FAIL_HI_OFS:   rd_mux = st_r.fail_hi;
      lhrs_pkg::ORG_ID_OFS:    rd_mux = lhrs_pkg::ORG_ID_VALUE;
      lhrs_pkg::FLAGS_SET_OFS: rd_mux = flags_view;
      lhrs_pkg::FLAGS_CLR_OFS: rd_mux = flags_view;
      lhrs_pkg::IRQ_STAT_OFS:  rd_mux = st_r.status;
      lhrs_pkg::IRQ_MASK_OFS:  rd_mux = st_r.mask;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt          = st_r;
    ev              = 32'h0000_0000;
    st_nxt.ack      = (read | write) & ~st_r.ack;
    st_nxt.xl_valid = 1'b0;
    if ((read | write) && !st_r.ack) begin
      st_nxt.rd_data = read ? rd_mux : 32'h0000_0000;
    end

    // Software writes; capture and id registers ignore writes
    if (wr_done) begin
      unique case (address)
        lhrs_pkg::ROM_BASE_OFS: begin
          st_nxt.base_pend = ((st_r.base_pend & ~lhrs_pkg::BASE_RW_MASK &
                              ~lhrs_be_mask(byteenable)) |
                              (st_r.base_pend & ~lhrs_be_mask(byteenable)) |
                              wmask) & lhrs_pkg::BASE_RW_MASK;
        end
        lhrs_pkg::FLAGS_SET_OFS: begin
          st_nxt.flags = st_r.flags |
                         (wmask & lhrs_pkg::FLAGS_RW_MASK);
          // Image flag may only be raised while the link is disabled
          if (st_r.flags[lhrs_pkg::FLG_LINK_EN]) begin
            st_nxt.flags[lhrs_pkg::FLG_IMAGE_OK] =
              st_r.flags[lhrs_pkg::FLG_IMAGE_OK];
          end
        end
        lhrs_pkg::FLAGS_CLR_OFS: begin
          st_nxt.flags = st_r.flags &
                         ~(wmask & lhrs_pkg::FLAGS_RW_MASK);
        end
        lhrs_pkg::IRQ_MASK_OFS: begin
          st_nxt.mask = ((st_r.mask & ~lhrs_be_mask(byteenable)) | wmask) &
                        lhrs_pkg::IRQ_BITS;
        end
        default: begin
        end
      endcase
    end

    // A failed fetch of the bus info block drops the image flag
    if (fetch_error) begin
      st_nxt.flags[lhrs_pkg::FLG_IMAGE_OK] = 1'b0;
    end

    // Failed posted write capture
    if (write_fail) begin
      st_nxt.fail_lo = write_fail_offset[31:0];
      st_nxt.fail_hi = {write_fail_source,
                        write_fail_offset[47:32]};
      ev[lhrs_pkg::IRQ_FAIL] = 1'b1;
    end

    // Pending base only goes live on a bus reset with a valid image,
    // so translation never shifts under an in-flight ROM read
    if (bus_reset && st_r.flags[lhrs_pkg::FLG_IMAGE_OK]) begin
      st_nxt.base_act = st_r.base_pend & lhrs_pkg::BASE_RW_MASK;
      ev[lhrs_pkg::IRQ_BASE_LOAD] = 1'b1;
    end

    if (rom_rd_req && in_window) begin
      st_nxt.xl_valid = 1'b1;
      st_nxt.xl_addr  = st_r.base_act +
                        {22'h00_0000, rom_rd_offset[9:0]};
      ev[lhrs_pkg::IRQ_ROM_READ] = 1'b1;
    end

    // Read clears only the bits it returned, so an event that lands
    // between the data capture and the completing edge is not lost
    if (rd_done && address == lhrs_pkg::IRQ_STAT_OFS) begin
      st_nxt.status = ((st_r.status & ~st_r.rd_data) | ev) &
                      lhrs_pkg::IRQ_BITS;
    end else begin
      st_nxt.status = (st_r.status | ev) & lhrs_pkg::IRQ_BITS;
    end

    if (rst) begin
      st_nxt           = '0;
      st_nxt.base_pend = lhrs_pkg::BASE_RST;
      st_nxt.base_act  = lhrs_pkg::BASE_RST;
      st_nxt.flags     = lhrs_pkg::FLAGS_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign readdata         = st_r.rd_data;
  assign rom_addr_valid   = st_r.xl_valid;
  assign rom_addr         = st_r.xl_addr;
  assign controller_flags = flags_view;
  assign irq              = |(st_r.status & st_r.mask);

  // ==========================================================
  // Checks
  rom_xlate_a : assert property (@(posedge ref_clk) disable iff (rst)
    rom_rd_req && in_window |=> rom_addr_valid &&
      rom_addr == $past(st_r.base_act) +
                  {22'h00_0000, $past(rom_rd_offset[9:0])})
    else $error("ROM address translation wrong");

  rom_window_a : assert property (@(posedge ref_clk) disable iff (rst)
    !(rom_rd_req && in_window) |=> !rom_addr_valid)
    else $error("ROM address valid without window read");

  base_low_a : assert property (@(posedge ref_clk) disable iff (rst)
    rd_done && address == lhrs_pkg::ROM_BASE_OFS |-> readdata[9:0] == 10'h000)
    else $error("ROM base reserved bits not zero");

  base_reset_a : assert property (@(posedge ref_clk) disable iff (rst)
    $past(rst) |-> st_r.base_pend == lhrs_pkg::BASE_RST &&
      st_r.base_act == lhrs_pkg::BASE_RST)
    else $error("ROM base not cleared by reset");

  base_write_a : assert property (@(posedge ref_clk) disable iff (rst)
    wr_done && address == lhrs_pkg::ROM_BASE_OFS && byteenable == 4'hF
      |=> st_r.base_pend == ($past(writedata) & lhrs_pkg::BASE_RW_MASK))
    else $error("ROM base write lost");

  fail_low_a : assert property (@(posedge ref_clk) disable iff (rst)
    write_fail |=> st_r.fail_lo == $past(write_fail_offset[31:0]))
    else $error("Failed offset low not captured");

  fail_high_a : assert property (@(posedge ref_clk) disable iff (rst)
    write_fail |=> st_r.fail_hi[15:0] == $past(write_fail_offset[47:32]))
    else $error("Failed offset high not captured");

  fail_source_a : assert property (@(posedge ref_clk) disable iff (rst)
    write_fail |=> st_r.fail_hi[31:22] == $past(write_fail_source[15:6]) &&
      st_r.fail_hi[21:16] == $past(write_fail_source[5:0]))
    else $error("Failed requester id not captured");

  fail_hold_a : assert property (@(posedge ref_clk) disable iff (rst)
    !write_fail |=> $stable(st_r.fail_lo) && $stable(st_r.fail_hi))
    else $error("Capture register changed without a failure");

  org_id_a : assert property (@(posedge ref_clk) disable iff (rst)
    rd_done && address == lhrs_pkg::ORG_ID_OFS
      |-> readdata == lhrs_pkg::ORG_ID_VALUE)
    else $error("Organisation id read wrong");

  flags_set_a : assert property (@(posedge ref_clk) disable iff (rst)
    wr_done && address == lhrs_pkg::FLAGS_SET_OFS &&
      byteenable == 4'hF && writedata[29]
      |=> controller_flags[29])
    else $error("Flag set write failed");

  flags_clear_a : assert property (@(posedge ref_clk) disable iff (rst)
    wr_done && address == lhrs_pkg::FLAGS_CLR_OFS && byteenable == 4'hF
      |=> (controller_flags & $past(writedata) &
           lhrs_pkg::FLAGS_RW_MASK) == 32'h0000_0000 &&
        (controller_flags | $past(writedata)) ==
        ($past(controller_flags) | $past(writedata)))
    else $error("Flag clear write wrong");

  flags_reset_a : assert property (@(posedge ref_clk) disable iff (rst)
    $past(rst) |-> (controller_flags & 32'hBFFB_FFFF) == 32'h0080_0000)
    else $error("Flag reset value wrong");

  base_hold_a : assert property (@(posedge ref_clk) disable iff (rst)
    bus_reset && !st_r.flags[lhrs_pkg::FLG_IMAGE_OK] |=> $stable(st_r.base_act))
    else $error("ROM base loaded with image flag clear");

  base_stable_a : assert property (@(posedge ref_clk) disable iff (rst)
    !bus_reset |=> $stable(st_r.base_act))
    else $error("Active ROM base changed between bus resets");

  base_load_a : assert property (@(posedge ref_clk) disable iff (rst)
    bus_reset && st_r.flags[lhrs_pkg::FLG_IMAGE_OK]
      |=> st_r.base_act == $past(st_r.base_pend))
    else $error("Pending ROM base not loaded at bus reset");

  bus_answer_a : assert property (@(posedge ref_clk) disable iff (rst)
    (read | write) && waitrequest |=> ((read | write) -> !waitrequest))
    else $error("Bus answer later than one wait state");

endmodule : lhrs_regs
